// ==== logic/dipg_issue_ctrl.sv ====
// Issue sequencer of the dual-issue in-order pipeline, with its two lanes.
// Assumes the fetch path presents two predecoded instructions in program order and
// shifts slot 1 into slot 0 when only slot 0 is taken.
`timescale 1ns/10ps
`default_nettype none
module dipg_issue_ctrl
    import dipg_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Older fetched instruction
    input wire logic slot0_valid,
    input wire dipg_kind_type slot0_kind,
    input wire logic slot0_dst_valid,
    input wire logic [REG_W-1:0] slot0_dst,
    input wire logic [LAT_W-1:0] slot0_latency,
    // Younger fetched instruction
    input wire logic slot1_valid,
    input wire dipg_kind_type slot1_kind,
    input wire logic slot1_src_a_valid,
    input wire logic [REG_W-1:0] slot1_src_a,
    input wire logic slot1_src_b_valid,
    input wire logic [REG_W-1:0] slot1_src_b,
    // Fetch handshake
    output logic take0,
    output logic take1,
    output logic busy,
    // Lane stage occupancy
    output logic [LANES-1:0] dec_valid,
    output logic [LANES-1:0] exe_valid,
    output dipg_exec_type [LANES-1:0] exe_kind,
    output logic [LANES-1:0] acc_valid,
    output dipg_access_type [LANES-1:0] acc_kind,
    output logic [LANES-1:0] iwb_valid,
    output logic [LANES-1:0][FSUB_N-1:0] fsub_valid,
    output logic [LANES-1:0] fwb_valid
);

    // ==========================================================
    // Sequencer state
    typedef enum logic {st_idle = 1'b0, st_slices = 1'b1} dipg_state_type;

    dipg_state_type state_r;
    dipg_kind_type kind_r;
    logic [SLICE_W-1:0] slice_r;
    logic [SLICE_W-1:0] slices_r;
    logic [LAT_W-1:0] hold_r;
    logic raw_hit;
    logic pairable;
    logic [SLICE_W-1:0] slot0_slices;
    dipg_token_type tok [LANES];

    // Flow dependency of the younger on the older destination
    assign raw_hit = slot0_dst_valid &&
                     ((slot1_src_a_valid && slot1_src_a == slot0_dst) ||
                      (slot1_src_b_valid && slot1_src_b == slot0_dst));
    // Group table, so add followed by unconditional branch pairs
    assign pairable = pair_ok(kind_group(slot0_kind), kind_group(slot1_kind));
    assign slot0_slices = kind_slices(slot0_kind);

    // Handshakes: slot 0 always first, slot 1 only with it
    assign take0 = (state_r == st_idle) && (hold_r == LAT_NONE) && slot0_valid;
    assign take1 = take0 && slot1_valid && pairable && !raw_hit;
    assign busy = (state_r != st_idle) || (hold_r != LAT_NONE);

    // Slice stream: lane 0 carries every multi-slice instruction
    always_comb begin
        if (state_r == st_slices) begin
            tok[0] = make_token(1'b1, kind_r, slice_r);
        end else begin
            tok[0] = make_token(take0, slot0_kind, SLICE_FIRST);
        end
        tok[1] = make_token(take1, slot1_kind, SLICE_FIRST);
    end

    // Slice walk through the issue cycles of one instruction
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_r <= st_idle;
            kind_r <= k_nop;
            slice_r <= SLICE_FIRST;
            slices_r <= SLICES_ONE;
        end else begin
            case (state_r)
                st_idle: begin
                    if (take0 && slot0_slices != SLICES_ONE) begin
                        state_r <= st_slices;
                        kind_r <= slot0_kind;
                        slice_r <= SLICE_STEP;
                        slices_r <= slot0_slices;
                    end
                end
                st_slices: begin
                    if (slice_r == slices_r - SLICE_STEP) begin
                        state_r <= st_idle;
                        slice_r <= SLICE_FIRST;
                    end else begin
                        slice_r <= slice_r + SLICE_STEP;
                    end
                end
                default: begin
                    state_r <= st_idle;
                end
            endcase
        end
    end

    // Dependency hold: the split-off younger waits until the older result exists.
    // Counted from the older issue, so it overlaps any remaining slices.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            hold_r <= LAT_NONE;
        end else if (take0 && !take1 && slot1_valid && raw_hit && slot0_latency > LAT_STEP) begin
            hold_r <= slot0_latency - LAT_STEP;
        end else if (hold_r != LAT_NONE) begin
            hold_r <= hold_r - LAT_STEP;
        end
    end

    // ==========================================================
    // Lanes
    for (genvar g = 0; g < LANES; g++) begin : g_lane
        dipg_slice_if slot_if ();
        assign slot_if.tok = tok[g];
        dipg_lane u_lane (
            .clk(clk),
            .rst(rst),
            .slot(slot_if.lane),
            .dec_valid(dec_valid[g]),
            .exe_valid(exe_valid[g]),
            .exe_kind(exe_kind[g]),
            .acc_valid(acc_valid[g]),
            .acc_kind(acc_kind[g]),
            .iwb_valid(iwb_valid[g]),
            .fsub_valid(fsub_valid[g]),
            .fwb_valid(fwb_valid[g])
        );
    end

endmodule
`default_nettype wire

// ==== logic/dipg_pkg.sv ====
// Shared types, tables and constants of the dual-issue grouping control.
// Assumes one core clock drives every user of these definitions.
package dipg_pkg;

    // ==========================================================
    // Widths and counts
    localparam int SLICE_W = 3;
    localparam int LAT_W = 4;
    localparam int REG_W = 4;
    localparam int LANES = 2;
    localparam int FSUB_N = 4;
    localparam int LANE_DEPTH = 6;

    // Positions of a token in the lane shift chain
    localparam int POS_DEC = 0;
    localparam int POS_EXE = 1;
    localparam int POS_ACC = 2;
    localparam int POS_IWB = 3;
    localparam int POS_F0 = 1;
    localparam int POS_FWB = 5;

    // Issue cycles of each execution pattern
    localparam logic [SLICE_W-1:0] SLICES_ONE = 3'h1;
    localparam logic [SLICE_W-1:0] SLICES_JUMP = 3'h2;
    localparam logic [SLICE_W-1:0] SLICES_BTEST = 3'h3;
    localparam logic [SLICE_W-1:0] SLICES_BRMW = 3'h4;
    localparam logic [SLICE_W-1:0] SLICES_TAS = 3'h5;
    localparam logic [SLICE_W-1:0] SLICES_RTE = 3'h5;
    localparam logic [SLICE_W-1:0] SLICES_SLEEP = 3'h4;
    localparam logic [SLICE_W-1:0] SLICE_FIRST = 3'h0;
    localparam logic [SLICE_W-1:0] SLICE_TAS_SECOND = 3'h1;
    localparam logic [SLICE_W-1:0] SLICE_STEP = 3'h1;
    localparam logic [LAT_W-1:0] LAT_STEP = 4'h1;
    localparam logic [LAT_W-1:0] LAT_NONE = 4'h0;

    // ==========================================================
    // Instruction kinds as presented by the predecoder
    typedef enum logic [4:0] {
        k_mov_reg = 5'h00, k_cmp = 5'h01, k_tflag = 5'h02, k_tst_reg = 5'h03,
        k_nop = 5'h04, k_arith = 5'h05, k_branch_cond = 5'h06,
        k_unconditional_branch = 5'h07, k_float_comm_register = 5'h08,
        k_float_const = 5'h09, k_float_move = 5'h0A, k_float_absneg = 5'h0B,
        k_load_store = 5'h0C, k_translation_entry_load = 5'h0D,
        k_prefetch_op = 5'h0E, k_global_base_ls = 5'h0F, k_reg_jump = 5'h10,
        k_byte_mem_test = 5'h11, k_byte_logic_rmw = 5'h12,
        k_byte_test_and_set = 5'h13, k_exception_return = 5'h14,
        k_sleep = 5'h15, k_float_exec = 5'h16, k_serial_other = 5'h17
    } dipg_kind_type;

    typedef enum logic [2:0] {
        move_test_group = 3'h0, integer_arith_group = 3'h1, branch_group = 3'h2,
        load_store_group = 3'h3, float_exec_group = 3'h4, serialising_group = 3'h5
    } dipg_group_type;

    typedef enum logic [1:0] {
        normal_execute_stage = 2'h0, special_execute_stage = 2'h1,
        float_execute_stage = 2'h2
    } dipg_exec_type;

    typedef enum logic {no_access_stage = 1'b0, memory_access_stage = 1'b1} dipg_access_type;
    typedef enum logic {int_writeback_stage = 1'b0, float_writeback_stage = 1'b1} dipg_wb_type;

    typedef struct packed {
        logic valid;
        dipg_exec_type exe;
        dipg_access_type acc;
        dipg_wb_type wb;
        dipg_group_type grp;
        logic [SLICE_W-1:0] slice;
    } dipg_token_type;

    // ==========================================================
    // Classification tables
    function automatic dipg_group_type kind_group(input dipg_kind_type k);
        case (k)
            k_mov_reg, k_cmp, k_tflag, k_tst_reg, k_nop: kind_group = move_test_group;
            k_arith: kind_group = integer_arith_group;
            k_branch_cond, k_unconditional_branch: kind_group = branch_group;
            k_float_comm_register, k_float_const, k_float_move, k_float_absneg,
            k_load_store, k_translation_entry_load, k_prefetch_op, k_global_base_ls:
                kind_group = load_store_group;
            k_float_exec: kind_group = float_exec_group;
            default: kind_group = serialising_group;
        endcase
    endfunction

    function automatic logic [SLICE_W-1:0] kind_slices(input dipg_kind_type k);
        case (k)
            k_reg_jump: kind_slices = SLICES_JUMP;
            k_byte_mem_test: kind_slices = SLICES_BTEST;
            k_byte_logic_rmw: kind_slices = SLICES_BRMW;
            k_byte_test_and_set: kind_slices = SLICES_TAS;
            k_exception_return: kind_slices = SLICES_RTE;
            k_sleep: kind_slices = SLICES_SLEEP;
            default: kind_slices = SLICES_ONE;
        endcase
    endfunction

    function automatic dipg_exec_type slice_exec(input dipg_kind_type k);
        case (k)
            k_global_base_ls, k_byte_mem_test, k_byte_logic_rmw: slice_exec = special_execute_stage;
            k_float_exec: slice_exec = float_execute_stage;
            default: slice_exec = normal_execute_stage;
        endcase
    endfunction

    function automatic dipg_access_type slice_access(input dipg_kind_type k,
                                                     input logic [SLICE_W-1:0] s);
        logic last;
        last = (s == kind_slices(k) - SLICE_STEP);
        case (k)
            k_load_store, k_translation_entry_load, k_prefetch_op, k_global_base_ls:
                slice_access = memory_access_stage;
            k_byte_mem_test:
                slice_access = (s == SLICE_FIRST) ? memory_access_stage : no_access_stage;
            k_byte_logic_rmw:
                slice_access = (s == SLICE_FIRST || last) ? memory_access_stage : no_access_stage;
            k_byte_test_and_set:
                slice_access = (s == SLICE_FIRST || s == SLICE_TAS_SECOND || last) ?
                               memory_access_stage : no_access_stage;
            default: slice_access = no_access_stage;
        endcase
    endfunction

    function automatic dipg_wb_type kind_wb(input dipg_kind_type k);
        case (k)
            k_float_const, k_float_move, k_float_absneg, k_float_exec:
                kind_wb = float_writeback_stage;
            default: kind_wb = int_writeback_stage;
        endcase
    endfunction

    // Serialising never pairs, same group never pairs except move/test
    function automatic logic pair_ok(input dipg_group_type g0, input dipg_group_type g1);
        if (g0 == serialising_group || g1 == serialising_group) begin
            pair_ok = 1'b0;
        end else if (g0 == g1 && g0 != move_test_group) begin
            pair_ok = 1'b0;
        end else begin
            pair_ok = 1'b1;
        end
    endfunction

    function automatic dipg_token_type make_token(input logic v, input dipg_kind_type k,
                                                  input logic [SLICE_W-1:0] s);
        make_token.valid = v;
        make_token.exe = slice_exec(k);
        make_token.acc = slice_access(k, s);
        make_token.wb = kind_wb(k);
        make_token.grp = kind_group(k);
        make_token.slice = s;
    endfunction

endpackage

// ==== logic/dipg_slice_if.sv ====
// Carrier for one issued slice from the issue sequencer into a lane.
// Assumes both ends run on the core clock.
`timescale 1ns/10ps
`default_nettype none
interface dipg_slice_if;
    import dipg_pkg::*;
    dipg_token_type tok;
    modport issue (output tok);
    modport lane (input tok);
endinterface
`default_nettype wire

// ==== logic/dipg_lane.sv ====
// One issue lane: carries slice tokens through decode, execute, access and write-back.
// Assumes tokens arrive already classified; a token enters decode each cycle it is valid.
`timescale 1ns/10ps
`default_nettype none
module dipg_lane
    import dipg_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Issued slice
    dipg_slice_if.lane slot,
    // Stage occupancy
    output logic dec_valid,
    output logic exe_valid,
    output dipg_exec_type exe_kind,
    output logic acc_valid,
    output dipg_access_type acc_kind,
    output logic iwb_valid,
    output logic [FSUB_N-1:0] fsub_valid,
    output logic fwb_valid
);

    // ==========================================================
    // Token chain
    dipg_token_type pipe_r [LANE_DEPTH];

    // Integer tokens retire after write-back; float tokens run on through F3 and float write-back
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < LANE_DEPTH; i++) begin
                pipe_r[i] <= '0;
            end
        end else begin
            pipe_r[POS_DEC] <= slot.tok;
            for (int i = 1; i < LANE_DEPTH; i++) begin
                pipe_r[i] <= pipe_r[i-1];
                if (i > POS_IWB && pipe_r[i-1].exe != float_execute_stage) begin
                    pipe_r[i].valid <= 1'b0;
                end
            end
        end
    end

    // ==========================================================
    // Stage decode from the chain registers
    assign dec_valid = pipe_r[POS_DEC].valid;
    assign exe_valid = pipe_r[POS_EXE].valid && pipe_r[POS_EXE].exe != float_execute_stage;
    assign exe_kind = pipe_r[POS_EXE].exe;
    assign acc_valid = pipe_r[POS_ACC].valid && pipe_r[POS_ACC].exe != float_execute_stage;
    assign acc_kind = pipe_r[POS_ACC].acc;
    assign iwb_valid = pipe_r[POS_IWB].valid && pipe_r[POS_IWB].exe != float_execute_stage;
    assign fwb_valid = pipe_r[POS_FWB].valid && pipe_r[POS_FWB].exe == float_execute_stage;

    // Float sub-stages F0..F3
    always_comb begin
        for (int i = 0; i < FSUB_N; i++) begin
            fsub_valid[i] = pipe_r[POS_F0+i].valid && pipe_r[POS_F0+i].exe == float_execute_stage;
        end
    end

endmodule
`default_nettype wire

// ==== dv/dipg_issue_monitor.sv ====
// Concurrent checks on the issue control ports.
// Assumes one core clock; bound from the bench top.
`timescale 1ns/10ps
`default_nettype none
module dipg_issue_monitor
    import dipg_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Fetch side
    input wire dipg_kind_type slot0_kind,
    input wire dipg_kind_type slot1_kind,
    input wire logic take0,
    input wire logic take1,
    input wire logic busy,
    // Lanes
    input wire logic [LANES-1:0] dec_valid,
    input wire logic [LANES-1:0] exe_valid,
    input wire logic [LANES-1:0] acc_valid,
    input wire logic [LANES-1:0] iwb_valid,
    input wire logic [LANES-1:0][FSUB_N-1:0] fsub_valid,
    input wire logic [LANES-1:0] fwb_valid
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    // ==========================================================
    // Issue handshake
    a_pair_needs_first: assert property (take1 |-> take0)
        else $error("younger issued without older");
    a_busy_blocks_take: assert property (busy |-> !take0)
        else $error("issue during slice walk");
    a_issue_to_decode: assert property (take0 |=> dec_valid[0])
        else $error("issued slice missing in decode");
    a_pair_to_decode: assert property (take1 |=> dec_valid[1])
        else $error("paired slice missing in decode");
    a_arith_not_paired: assert property (take0 && slot0_kind == k_arith && slot1_kind == k_arith
        |-> !take1)
        else $error("two arithmetic paired");
    a_serial_not_paired: assert property (take0 && slot1_kind == k_serial_other |-> !take1)
        else $error("serialising paired");
    // ==========================================================
    // Stage sequences
    a_decode_advance: assert property (dec_valid[0] |=> exe_valid[0] || fsub_valid[0][0])
        else $error("decode did not advance");
    a_int_chain: assert property (exe_valid[0] |=> acc_valid[0] ##1 iwb_valid[0])
        else $error("integer chain broken");
    a_float_chain: assert property (fsub_valid[0][0] |=> fsub_valid[0][1] ##1 fsub_valid[0][2]
        ##1 fsub_valid[0][3] ##1 fwb_valid[0])
        else $error("float chain broken");
    // The paired lane must walk the same stage sequences as the older lane
    a_pair_advance: assert property (dec_valid[1] |=> exe_valid[1] || fsub_valid[1][0])
        else $error("paired decode did not advance");
    a_pair_int_chain: assert property (exe_valid[1] |=> acc_valid[1] ##1 iwb_valid[1])
        else $error("paired integer chain broken");
    a_pair_float_chain: assert property (fsub_valid[1][0] |=> fsub_valid[1][1] ##1 fsub_valid[1][2]
        ##1 fsub_valid[1][3] ##1 fwb_valid[1])
        else $error("paired float chain broken");
    // Main scenarios reached
    c_paired: cover property (take1);
    c_walk_end: cover property (busy ##1 !busy);
    c_float: cover property (fsub_valid[0][0]);
endmodule
`default_nettype wire

// ==== dv/dipg_fetch_model.sv ====
// Fetch path model: presents queued instructions in program order.
// Assumes the bench queues entries just after a rising edge.
`timescale 1ns/10ps
`default_nettype none
module dipg_fetch_model
    import dipg_pkg::*;
(
    // Clock, reset and handshake
    input wire logic clk,
    input wire logic rst,
    input wire logic take0,
    input wire logic take1,
    // Presented slots
    output logic s0_v,
    output logic s1_v,
    output dipg_kind_type s0_k,
    output dipg_kind_type s1_k,
    output logic [REG_W-1:0] s0_d,
    output logic [LAT_W-1:0] s0_lat,
    output logic [REG_W-1:0] s1_a,
    output logic [REG_W-1:0] s1_b
);
    typedef struct packed {
        dipg_kind_type k;
        logic [REG_W-1:0] d;
        logic [REG_W-1:0] a;
        logic [REG_W-1:0] b;
        logic [LAT_W-1:0] lat;
    } dipg_entry_type;
    dipg_entry_type q[$];
    dipg_entry_type e0 = '0;
    dipg_entry_type e1 = '0;
    logic v0 = 1'b0;
    logic v1 = 1'b0;
    int seed = 32'h7E4C;
    task automatic push(input dipg_kind_type k, input logic [3:0] d, a, b, lat);
        q.push_back('{k, d, a, b, lat});
    endtask
    // Consume what the design took; the younger slides to the front
    always @(posedge clk) begin
        if (!rst && take0 && q.size() > 0) begin
            void'(q.pop_front());
            if (take1 && q.size() > 0) begin
                void'(q.pop_front());
            end
        end
    end
    // Empty slots carry junk so a stale value never looks valid
    always @(negedge clk) begin
        v0 <= q.size() > 0;
        v1 <= q.size() > 1;
        e0 <= (q.size() > 0) ? q[0] : dipg_entry_type'($random(seed));
        e1 <= (q.size() > 1) ? q[1] : dipg_entry_type'($random(seed));
    end
    assign s0_v = v0;
    assign s1_v = v1;
    assign s0_k = e0.k;
    assign s1_k = e1.k;
    assign s0_d = e0.d;
    assign s0_lat = e0.lat;
    assign s1_a = e1.a;
    assign s1_b = e1.b;
endmodule
`default_nettype wire

// ==== dv/tb.sv ====
// Self-checking bench of the issue control with a fetch model.
// Assumes register 0 means no operand.
`timescale 1ns/10ps
`default_nettype none
module tb
    import dipg_pkg::*;
();
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic s0_v, s1_v, take0, take1, busy;
    dipg_kind_type s0_k, s1_k;
    logic [REG_W-1:0] s0_d, s1_a, s1_b;
    logic [LAT_W-1:0] s0_lat;
    logic [LANES-1:0] dec_v, exe_v, acc_v, iwb_v, fwb_v;
    dipg_exec_type [LANES-1:0] exe_k;
    dipg_access_type [LANES-1:0] acc_k;
    logic [LANES-1:0][FSUB_N-1:0] fsub_v;
    int seed = 32'h7E4C;
    int miscompares = 0;
    int n_checks = 0;
    int cyc = 0;
    int n_mem = 0;
    int n_spx = 0;
    int take_log[$];
    dipg_kind_type reps[6] = '{k_nop, k_arith, k_unconditional_branch, k_load_store,
        k_float_exec, k_serial_other};
    dipg_issue_ctrl i_dipg_issue_ctrl (.clk(clk), .rst(rst), .slot0_valid(s0_v),
        .slot0_kind(s0_k), .slot0_dst_valid(s0_d != 4'h0), .slot0_dst(s0_d),
        .slot0_latency(s0_lat), .slot1_valid(s1_v), .slot1_kind(s1_k),
        .slot1_src_a_valid(s1_a != 4'h0), .slot1_src_a(s1_a),
        .slot1_src_b_valid(s1_b != 4'h0), .slot1_src_b(s1_b), .take0(take0), .take1(take1),
        .busy(busy), .dec_valid(dec_v), .exe_valid(exe_v), .exe_kind(exe_k),
        .acc_valid(acc_v), .acc_kind(acc_k), .iwb_valid(iwb_v), .fsub_valid(fsub_v),
        .fwb_valid(fwb_v));
    dipg_fetch_model i_dipg_fetch_model (.clk(clk), .rst(rst), .take0(take0), .take1(take1),
        .s0_v(s0_v), .s1_v(s1_v), .s0_k(s0_k), .s1_k(s1_k), .s0_d(s0_d), .s0_lat(s0_lat),
        .s1_a(s1_a), .s1_b(s1_b));
    always #20 clk = ~clk;
    // ==========================================================
    // Expectations and comparisons
    function automatic int grp(input dipg_kind_type k);
        case (k)
            k_mov_reg, k_cmp, k_tflag, k_tst_reg, k_nop: return 0;
            k_arith: return 1;
            k_branch_cond, k_unconditional_branch: return 2;
            k_float_exec: return 4;
            default: return (k >= k_reg_jump) ? 5 : 3;
        endcase
    endfunction
    function automatic logic exp_pair();
        logic dep;
        dep = s0_d != 4'h0 && (s1_a == s0_d || s1_b == s0_d);
        return s1_v && !dep && grp(s0_k) != 5 && grp(s1_k) != 5
            && (grp(s0_k) != grp(s1_k) || grp(s0_k) == 0);
    endfunction
    task automatic cmp_bit(input logic got, input logic exp, input string m);
        n_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("unexpected at %0t: %s", $time, m);
        end
    endtask
    task automatic cmp_int(input int got, input int exp, input string m);
        n_checks++;
        if (got != exp) begin
            miscompares++;
            $display("unexpected at %0t: %s got %0d", $time, m, got);
        end
    endtask
    task automatic complete_run();
        $display("checks %0d mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    // Issue log, stage counters, pairing watch and hang guard
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (!rst && take0) take_log.push_back(cyc);
        if (!rst && acc_v[0] && acc_k[0] == memory_access_stage) n_mem++;
        if (!rst && exe_v[0] && exe_k[0] == special_execute_stage) n_spx++;
        if (!rst && take0) cmp_bit(take1, exp_pair(), "pairing");
        if (cyc > 30000) begin
            miscompares++;
            complete_run();
        end
    end
    // ==========================================================
    // Scenario tasks
    task automatic drain();
        int n;
        n = 0;
        while ((i_dipg_fetch_model.q.size() > 0 || busy !== 1'b0) && n < 2000) begin
            @(posedge clk);
            n++;
        end
        // A stuck queue or walk must never slip through to the verdict
        if (n >= 2000) begin
            miscompares++;
            complete_run();
        end
        repeat (8) @(posedge clk);
        #1;
        take_log.delete();
    endtask
    task automatic walk(input dipg_kind_type k, input int sl, input int mem, input int spx);
        n_mem = 0;
        n_spx = 0;
        i_dipg_fetch_model.push(k, 4'h1, 4'h2, 4'h3, 4'h1);
        i_dipg_fetch_model.push(k_serial_other, 4'h0, 4'h0, 4'h0, 4'h1);
        repeat (40) @(posedge clk);
        cmp_int(take_log[1] - take_log[0], sl, "issue cycles");
        cmp_int(n_mem, mem, "memory slices");
        cmp_int(n_spx, spx, "special slices");
        drain();
        $display("walk %s done", k.name());
    endtask
    task automatic dep(input logic [3:0] lat);
        i_dipg_fetch_model.push(k_arith, 4'h5, 4'h0, 4'h0, lat);
        i_dipg_fetch_model.push(k_load_store, 4'h0, 4'h5, 4'h0, 4'h1);
        repeat (40) @(posedge clk);
        cmp_int(take_log[1] - take_log[0], (lat > 1) ? lat : 1, "hold");
        drain();
    endtask
    initial begin
        repeat (20) @(posedge clk);
        @(negedge clk) rst = 1'b0;
        drain();
        walk(k_arith, 1, 0, 0);
        walk(k_float_absneg, 1, 0, 0);
        walk(k_prefetch_op, 1, 1, 0);
        walk(k_global_base_ls, 1, 1, 1);
        walk(k_reg_jump, 2, 0, 0);
        walk(k_byte_mem_test, 3, 1, 3);
        walk(k_byte_logic_rmw, 4, 2, 4);
        walk(k_byte_test_and_set, 5, 3, 0);
        walk(k_exception_return, 5, 0, 0);
        walk(k_sleep, 4, 0, 0);
        walk(k_float_exec, 1, 0, 0);
        $display("pair table");
        foreach (reps[i]) foreach (reps[j]) begin
            i_dipg_fetch_model.push(reps[i], 4'h1, 4'h0, 4'h0, 4'h1);
            i_dipg_fetch_model.push(reps[j], 4'h0, 4'h2, 4'h3, 4'h1);
            drain();
        end
        dep(4'h1);
        dep(4'h2);
        dep(4'hF);
        dep(4'($unsigned($random(seed)) % 16));
        $display("dependency done");
        repeat (120) begin
            i_dipg_fetch_model.push(dipg_kind_type'(5'($unsigned($random(seed)) % 24)),
                4'($random(seed) & 3), 4'($random(seed) & 3), 4'($random(seed) & 3),
                4'($random(seed) & 7));
        end
        drain();
        $display("random stream done");
        complete_run();
    end
endmodule
bind dipg_issue_ctrl dipg_issue_monitor i_mon (.clk(clk), .rst(rst), .slot0_kind(slot0_kind),
    .slot1_kind(slot1_kind), .take0(take0), .take1(take1), .busy(busy),
    .dec_valid(dec_valid), .exe_valid(exe_valid), .acc_valid(acc_valid),
    .iwb_valid(iwb_valid), .fsub_valid(fsub_valid), .fwb_valid(fwb_valid));
`default_nettype wire
